// ### rtl/pbid_map.svh
// Constants of the processor bus interface and front-end data path.
// Assumes inclusion by the package, the core module and the testbench.
`ifndef PBID_MAP_SVH
`define PBID_MAP_SVH
// Timing: slave answer limit and arbitration answer limit
`define PBID_DTO_NS        10000
`define PBID_ARB_NS        5000
`define PBID_CLK_NS        10
// Power sequencing step times
`define PBID_PWR_STEP_NS   20000
// Processor addresses decoded from the bus address register
`define PBID_SR_ADDR       16'hFF78
`define PBID_PS_ADDR       16'hFFFE
`define PBID_STACK_LIMIT   16'h0100
// Transfer type encodings, as carried by the microinstruction
`define PBID_XF_DATI       2'h0
`define PBID_XF_DATIP      2'h1
`define PBID_XF_DATO       2'h2
`define PBID_XF_DATOB      2'h3
// Data select mux encodings
`define PBID_DS_BUS        2'h0
`define PBID_DS_RD         2'h1
`define PBID_DS_D          2'h2
`define PBID_DS_DSHR       2'h3
`endif

// ### rtl/pbid_pkg.sv
// Types of the processor bus interface and front-end data path.
// Assumes the constants header sits beside it in rtl/.
package pbid_pkg;
   `include "pbid_map.svh"
   // Bus master transfer sequencer states
   typedef enum logic [2:0] {
      PBID_M_IDLE, PBID_M_ADDR, PBID_M_WAIT, PBID_M_HOLD, PBID_M_END
   } pbid_mst_t;
   // Ownership arbiter states
   typedef enum logic [1:0] {
      PBID_A_IDLE, PBID_A_GRANT, PBID_A_OWNED
   } pbid_arb_t;
   // Power sequencer states
   typedef enum logic [2:0] {
      PBID_P_DOWN, PBID_P_INIT, PBID_P_UP, PBID_P_ACLOW, PBID_P_DCLOW
   } pbid_pwr_t;
endpackage

// ### rtl/pbid_core.sv
// Processor bus interface, console front end and operand staging path.
// Assumes a microsequencer on clk_sys supplying microinstruction fields
// and bus pins already resolved to separate in/out/enable signals.
// Contract
// - Switch register address read on console drives switch value onto bus data.
// - Data display always shows the data select mux output.
// - Address display always shows the bus address register.
// - Console switch activations reported for microprogram branching.
// - Flags record start/continue and chain examine or deposit increments.
// - Performs read, read-pause, write and write-byte transfers on request.
// - Transfers checked for odd address, stack overflow and data time-out.
// - Addressed by another master, processor answers as a slave.
// - Grants ownership to requesters and times out a silent one.
// - Power-fail sequences AC low, DC low and init in fixed order.
// - Read data latched and master sync dropped by the next start or B, IR or D load.
// - Start and check flip-flops load from fields, plain or conditional.
// - Arbitration and power logic run independently of the microprogram.
// - Address, D, status and switch registers each have bus drivers.
// - Bus data enters through receivers into the data select mux.
// - Sixteen-entry scratchpad plus B, D, address, status, instruction.
// - Operand A comes straight from the scratchpad read bus.
// - Scratchpad accesses one address per cycle, never read and write.
// - B register stages an operand for the ALU B input.
`include "pbid_map.svh"
module pbid_core
   import pbid_pkg::*;
#(
   parameter int DTO_CYC = (`PBID_DTO_NS + `PBID_CLK_NS - 1) / `PBID_CLK_NS,
   parameter int ARB_CYC = (`PBID_ARB_NS + `PBID_CLK_NS - 1) / `PBID_CLK_NS,
   parameter int PWR_CYC = (`PBID_PWR_STEP_NS + `PBID_CLK_NS - 1)
                           / `PBID_CLK_NS
) (
   input  wire logic        clk_sys,      // Microcycle clock
   input  wire logic        srst,         // Synchronous reset
   // Microinstruction fields
   input  wire logic        ui_bus_start, // Start bus transfer
   input  wire logic        ui_start_cond,// Start only if condition
   input  wire logic        ui_cond,      // Branch condition
   input  wire logic [1:0]  ui_xfer,      // Transfer type
   input  wire logic        ui_chk_en,    // Load error checking
   input  wire logic        ui_sp_stack,  // Address is stack pointer use
   input  wire logic        ui_console,   // Console routine active
   input  wire logic [1:0]  ui_dsel,      // Data select mux choice
   input  wire logic        ui_ld_ba,     // Load bus address reg
   input  wire logic        ui_ld_d,      // Load D reg
   input  wire logic        ui_ld_b,      // Load B reg
   input  wire logic        ui_ld_ps,     // Load status reg
   input  wire logic        ui_ld_ir,     // Load instruction reg
   input  wire logic        ui_sp_wr,     // Scratchpad write
   input  wire logic        ui_sp_rd,     // Scratchpad read
   input  wire logic [3:0]  ui_sp_addr,   // Scratchpad address
   input  wire logic [15:0] alu_out,      // ALU result
   input  wire logic        ui_flag_clr,  // Clear start and continue flags
   // Operand outputs
   output logic      [15:0] operand_a,    // ALU A input
   output logic      [15:0] b_reg,        // Staged B operand
   output logic      [15:0] instruction_reg, // Instruction register
   output logic      [7:0]  processor_status_reg, // Status register
   output logic             busy,         // Transfer in progress
   output logic             err_odd,      // Odd address error
   output logic             err_stack,    // Stack overflow error
   output logic             err_dto,      // Data time-out error
   // Console
   input  wire logic [15:0] sw_reg,       // Switch register
   input  wire logic [5:0]  con_sw,       // Start,halt,ld,exam,dep,cont
   output logic      [5:0]  con_event,    // Switch activations
   output logic             flag_start,   // Start sequence flag
   output logic             flag_cont,    // Continue sequence flag
   output logic             flag_exam,    // Previous was examine
   output logic             flag_dep,     // Previous was deposit
   output logic             con_incr,     // Consecutive, advance addr
   output logic      [15:0] disp_data,    // Data display
   output logic      [15:0] disp_addr,    // Address display
   // System bus pins
   input  wire logic [15:0] bus_a_in,     // Address lines in
   output logic      [15:0] bus_a_out,    // Address lines out
   output logic             bus_a_oe,     // Address drive
   input  wire logic [15:0] bus_d_in,     // Data lines in
   output logic      [15:0] bus_d_out,    // Data lines out
   output logic             bus_d_oe,     // Data drive
   input  wire logic [1:0]  bus_c_in,     // Control lines in
   output logic      [1:0]  bus_c_out,    // Control lines out
   output logic             bus_c_oe,     // Control drive
   input  wire logic        msyn_in,      // Master sync in
   output logic             msyn_out,     // Master sync out
   input  wire logic        ssyn_in,      // Slave sync in
   output logic             ssyn_out,     // Slave sync out
   input  wire logic        nonprocessor_request, // Request, NONPROCESSOR_REQUEST
   input  wire logic        br_in,        // Priority bus request
   output logic             npg_out,      // NONPROCESSOR_REQUEST grant
   output logic             bg_out,       // Bus grant
   input  wire logic        sack_in,      // Selection acknowledge
   input  wire logic        bbsy_in,      // Bus busy in
   output logic             bbsy_out,     // Bus busy out
   output logic             arb_tmo,      // Ownership exchange timed out
   input  wire logic        pwr_ok,       // Supply good
   output logic             ac_low,       // Bus AC low
   output logic             dc_low,       // Bus DC low
   output logic             bus_init      // Bus initialize
);
   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [15:0] a_s1, a_s2, d_s1, d_s2, swr_s1, swr_s2;
   logic [1:0]  c_s1, c_s2;
   logic [8:0]  p_s1, p_s2;
   logic [5:0]  sw_s1, sw_s2, sw_prev;
   // Two stages each; only the second is read by logic
   always_ff @(posedge clk_sys) begin
      a_s1  <= bus_a_in;
      a_s2  <= a_s1;
      d_s1  <= bus_d_in;
      d_s2  <= d_s1;
      c_s1  <= bus_c_in;
      c_s2  <= c_s1;
      p_s1  <= {msyn_in, ssyn_in, nonprocessor_request, br_in, sack_in,
                bbsy_in, pwr_ok, 2'h0};
      p_s2  <= p_s1;
      sw_s1 <= con_sw;
      sw_s2 <= sw_s1;
      swr_s1 <= sw_reg;
      swr_s2 <= swr_s1;
   end
   wire msyn_s  = p_s2[8];
   wire ssyn_s  = p_s2[7];
   wire npr_s   = p_s2[6];
   wire br_s    = p_s2[5];
   wire sack_s  = p_s2[4];
   wire bbsy_s  = p_s2[3];
   wire pwrok_s = p_s2[2];

   // ---------------------------------------------------------------
   // Data path registers and scratchpad
   // ---------------------------------------------------------------
   logic [15:0] sp_mem [16];
   logic [15:0] sp_rd, d_reg, ba_reg, dmux, rd_latch;
   // Write has priority; a read is then suppressed in that cycle
   wire sp_do_wr = ui_sp_wr;
   wire sp_do_rd = ui_sp_rd && !ui_sp_wr;
   always_ff @(posedge clk_sys) begin
      if (sp_do_wr) sp_mem[ui_sp_addr] <= alu_out;
      if (sp_do_rd) sp_rd <= sp_mem[ui_sp_addr];
   end
   // Operand A is the read bus, unmuxed
   assign operand_a = sp_rd;
   // Data select mux: bus receivers, read bus, D, D shifted right
   assign dmux = (ui_dsel == `PBID_DS_BUS) ? rd_latch :
                 (ui_dsel == `PBID_DS_RD)  ? sp_rd :
                 (ui_dsel == `PBID_DS_D)   ? d_reg :
                 {1'b0, d_reg[15:1]};
   // Registers of the data path
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         b_reg <= 16'h0000;
         d_reg <= 16'h0000;
         ba_reg <= 16'h0000;
         processor_status_reg <= 8'h00;
         instruction_reg <= 16'h0000;
      end else begin
         if (ui_ld_b)  b_reg <= dmux;
         if (ui_ld_d)  d_reg <= alu_out;
         if (ui_ld_ba) ba_reg <= alu_out;
         if (ui_ld_ps) processor_status_reg <= dmux[7:0];
         if (ui_ld_ir) instruction_reg <= dmux;
      end
   end
   // Displays register the mux and address register, one cycle behind
   always_ff @(posedge clk_sys) begin
      disp_data <= dmux;
      disp_addr <= ba_reg;
   end

   // ---------------------------------------------------------------
   // Console switches and flags
   // ---------------------------------------------------------------
   wire [5:0] sw_rise = sw_s2 & ~sw_prev;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sw_prev <= 6'h00;
         con_event <= 6'h00;
         flag_start <= 1'b0;
         flag_cont <= 1'b0;
         flag_exam <= 1'b0;
         flag_dep <= 1'b0;
         con_incr <= 1'b0;
      end else begin
         sw_prev <= sw_s2;
         con_event <= sw_rise;
         // Set wins over the microprogram's clear
         flag_start <= sw_rise[0] | (flag_start & ~ui_flag_clr);
         flag_cont  <= sw_rise[5] | (flag_cont & ~ui_flag_clr);
         if (sw_rise[3]) begin
            con_incr <= flag_exam;
            flag_exam <= 1'b1;
            flag_dep <= 1'b0;
         end else if (sw_rise[4]) begin
            con_incr <= flag_dep;
            flag_dep <= 1'b1;
            flag_exam <= 1'b0;
         end else if (|sw_rise) begin
            con_incr <= 1'b0;                       // Other switch breaks chain
            flag_exam <= 1'b0;
            flag_dep <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Master transfers and error checking
   // ---------------------------------------------------------------
   localparam int DTOW = $clog2(DTO_CYC + 1);
   pbid_mst_t   mst, next_mst;
   logic [1:0]  xfer;
   logic [DTOW-1:0] dto_cnt;
   wire is_sr = (ba_reg == `PBID_SR_ADDR);
   wire is_ps = (ba_reg == `PBID_PS_ADDR);
   wire is_rd = (xfer == `PBID_XF_DATI) || (xfer == `PBID_XF_DATIP);
   // Start loads plainly or only under the condition
   wire go = ui_bus_start && (!ui_start_cond || ui_cond);
   wire odd_bad = ba_reg[0] && (ui_xfer != `PBID_XF_DATOB);
   wire stk_bad = ui_sp_stack && (ba_reg < `PBID_STACK_LIMIT);
   wire check = go && ui_chk_en;
   wire start_ok = go && !(ui_chk_en && (odd_bad || stk_bad));
   wire dto_hit = (dto_cnt == DTOW'(DTO_CYC));
   // Next state: read ends on the next start or B, IR or D load
   always_comb begin
      next_mst = mst;
      case (mst)
         PBID_M_IDLE: if (start_ok && !bbsy_s) next_mst = PBID_M_ADDR;
         PBID_M_ADDR: next_mst = PBID_M_WAIT;
         PBID_M_WAIT: begin
            if (dto_hit)     next_mst = PBID_M_END;
            else if (ssyn_s) next_mst = is_rd ? PBID_M_HOLD : PBID_M_END;
         end
         PBID_M_HOLD: if (ui_bus_start || ui_ld_b || ui_ld_ir ||
                          ui_ld_d) next_mst = PBID_M_END;
         PBID_M_END:  next_mst = PBID_M_IDLE;
         default:     next_mst = PBID_M_IDLE;
      endcase
   end
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         mst <= PBID_M_IDLE;
         xfer <= `PBID_XF_DATI;
         dto_cnt <= '0;
         rd_latch <= 16'h0000;
         err_odd <= 1'b0;
         err_stack <= 1'b0;
         err_dto <= 1'b0;
      end else begin
         mst <= next_mst;
         if (mst == PBID_M_IDLE && start_ok) xfer <= ui_xfer;
         dto_cnt <= (mst == PBID_M_WAIT) ? dto_cnt + DTOW'(1) : '0;
         if (mst == PBID_M_HOLD && next_mst == PBID_M_END)
            rd_latch <= d_s2;
         if (check) begin
            err_odd <= odd_bad;
            err_stack <= stk_bad;
         end
         if (mst == PBID_M_WAIT && dto_hit) err_dto <= 1'b1;
         else if (check) err_dto <= 1'b0;
      end
   end
   wire m_own = (mst != PBID_M_IDLE);
   assign busy = m_own;

   // ---------------------------------------------------------------
   // Slave response to other masters
   // ---------------------------------------------------------------
   logic slv_ack;
   wire hit_sr = (a_s2 == `PBID_SR_ADDR);
   wire hit_ps = (a_s2 == `PBID_PS_ADDR);
   wire s_sel  = !m_own && msyn_s && (hit_sr || hit_ps);
   wire s_read = !c_s2[1];
   always_ff @(posedge clk_sys) begin
      if (srst) slv_ack <= 1'b0;
      else      slv_ack <= s_sel;
   end

   // ---------------------------------------------------------------
   // Bus drivers
   // ---------------------------------------------------------------
   // Switch drivers: console or slave reads
   wire drv_sw  = (m_own && ui_console && is_sr && is_rd) ||
                  (slv_ack && hit_sr && s_read);
   wire drv_ps  = (slv_ack && hit_ps && s_read) ||
                  (m_own && is_ps && is_rd);
   wire drv_d   = m_own && !is_rd && !is_sr;
   assign bus_d_out = drv_sw ? swr_s2 :
                      drv_ps ? {8'h00, processor_status_reg} :
                      d_reg;
   assign bus_d_oe  = drv_sw || drv_ps || drv_d;
   assign bus_a_out = ba_reg;
   assign bus_a_oe  = m_own;
   assign bus_c_out = xfer;
   assign bus_c_oe  = m_own;
   assign msyn_out  = (mst == PBID_M_WAIT) || (mst == PBID_M_HOLD);
   assign ssyn_out  = slv_ack;
   assign bbsy_out  = m_own;

   // ---------------------------------------------------------------
   // Ownership arbitration, free of the microprogram
   // ---------------------------------------------------------------
   localparam int ARBW = $clog2(ARB_CYC + 1);
   pbid_arb_t arb;
   logic [ARBW-1:0] arb_cnt;
   logic gnt_npr;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         arb <= PBID_A_IDLE;
         arb_cnt <= '0;
         gnt_npr <= 1'b0;
         arb_tmo <= 1'b0;
      end else begin
         arb_tmo <= 1'b0;
         case (arb)
            PBID_A_IDLE: if (!m_own && (npr_s || br_s)) begin
               arb <= PBID_A_GRANT;
               gnt_npr <= npr_s;                                // NONPROCESSOR_REQUEST first
               arb_cnt <= '0;
            end
            PBID_A_GRANT: begin
               arb_cnt <= arb_cnt + ARBW'(1);
               if (sack_s) arb <= PBID_A_OWNED;
               else if (arb_cnt == ARBW'(ARB_CYC)) begin
                  arb <= PBID_A_IDLE;
                  arb_tmo <= 1'b1;
               end
            end
            PBID_A_OWNED: if (!sack_s && !bbsy_s) arb <= PBID_A_IDLE;
            default: arb <= PBID_A_IDLE;
         endcase
      end
   end
   assign npg_out = (arb == PBID_A_GRANT) && gnt_npr;
   assign bg_out  = (arb == PBID_A_GRANT) && !gnt_npr;

   // ---------------------------------------------------------------
   // Power sequencing, free of the microprogram
   // ---------------------------------------------------------------
   localparam int PWRW = $clog2(PWR_CYC + 1);
   pbid_pwr_t pwr;
   logic [PWRW-1:0] pwr_cnt;
   wire pwr_done = (pwr_cnt == PWRW'(PWR_CYC));
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         pwr <= PBID_P_DOWN;
         pwr_cnt <= '0;
      end else begin
         pwr_cnt <= pwr_done ? '0 : pwr_cnt + PWRW'(1);
         case (pwr)
            // Up: DC high, then init drops as AC goes high
            PBID_P_DOWN:  if (pwrok_s && pwr_done) pwr <= PBID_P_INIT;
            PBID_P_INIT:  if (pwr_done) pwr <= PBID_P_UP;
            PBID_P_UP:    if (!pwrok_s) begin
               pwr <= PBID_P_ACLOW;
               pwr_cnt <= '0;
            end
            // Down: AC low, wait, then DC low with init
            PBID_P_ACLOW: if (pwr_done) pwr <= PBID_P_DCLOW;
            PBID_P_DCLOW: if (pwr_done) pwr <= PBID_P_DOWN;
            default:      pwr <= PBID_P_DOWN;
         endcase
      end
   end
   assign ac_low   = (pwr != PBID_P_UP);
   assign dc_low   = (pwr == PBID_P_DOWN) || (pwr == PBID_P_DCLOW);
   assign bus_init = (pwr != PBID_P_UP) && (pwr != PBID_P_ACLOW);

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   sequence s_rd_hold;
      mst == PBID_M_HOLD;
   endsequence
   a_msyn_hold: assert property (@(posedge clk_sys) disable iff (srst)
      s_rd_hold |-> msyn_out) else $error("msyn dropped early");
   a_dto_raise: assert property (@(posedge clk_sys) disable iff (srst)
      (mst == PBID_M_WAIT && dto_hit) |=> err_dto)
      else $error("time-out not flagged");
   a_odd_block: assert property (@(posedge clk_sys) disable iff (srst)
      (mst == PBID_M_IDLE && go && ui_chk_en && odd_bad) |=> !m_own)
      else $error("odd address started");
   a_sw_drive: assert property (@(posedge clk_sys) disable iff (srst)
      (m_own && ui_console && is_sr && is_rd) |-> bus_d_out == swr_s2)
      else $error("switches not driven");
   a_addr_disp: assert property (@(posedge clk_sys) disable iff (srst)
      ##1 disp_addr == $past(ba_reg)) else $error("address display");
   a_sp_one: assert property (@(posedge clk_sys) disable iff (srst)
      !(sp_do_rd && sp_do_wr)) else $error("scratchpad read and write");
   a_arb_tmo: assert property (@(posedge clk_sys) disable iff (srst)
      arb_tmo |-> $past(arb) == PBID_A_GRANT) else $error("bad arb timeout");
   a_pwr_order: assert property (@(posedge clk_sys) disable iff (srst)
      dc_low |-> ac_low && bus_init) else $error("power order");
endmodule

// ### verif/pbid_slave_model.sv
// Bus slave model: a small word memory answering master transfers.
// Assumes the design's bus pins split into in/out/enable, on clk_sys.
module pbid_slave_model #(
   parameter int LAT = 3                // Wait cycles counted after master sync; answer comes one cycle later
) (
   input  wire logic        clk_sys,   // Bus clock
   input  wire logic        mute,      // Never answer while high
   input  wire logic [15:0] bus_a_out, // Address from master
   input  wire logic [15:0] bus_d_out, // Write data from master
   input  wire logic [1:0]  bus_c_out, // Transfer type from master
   input  wire logic        msyn_out,  // Master sync
   output logic      [15:0] bus_d_in,  // Read data to master
   output logic             ssyn_in    // Slave sync to master
);
   logic [15:0] mem [16];
   int          wait_cnt;
   // Known contents
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = 16'hA500 + 16'(i);
      bus_d_in = 16'h0000;
      ssyn_in  = 1'b0;
      wait_cnt = 0;
   end
   // Answer one cycle after LAT wait cycles counted from sync; whole words only
   always @(posedge clk_sys) begin
      if (!msyn_out) begin
         if (ssyn_in)
            bus_d_in <= ~bus_d_in; // Released lines must not look valid
         ssyn_in  <= 1'b0;
         wait_cnt <= 0;
      end else if (wait_cnt < LAT) begin
         wait_cnt <= wait_cnt + 1;
      end else if (!mute && !ssyn_in) begin // Silent slave on request
         ssyn_in <= 1'b1;
         if (bus_c_out[1])
            mem[bus_a_out[4:1]] <= bus_d_out;
         else
            bus_d_in <= mem[bus_a_out[4:1]];
      end
   end
endmodule

// ### verif/test_processor_bus_interface_datapath.sv
// Self-checking bench of the bus interface and operand path.
// Assumes rtl/ compiled first and the slave model beside this file.
`include "pbid_map.svh"
module test_processor_bus_interface_datapath;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, srst, ui_bus_start, ui_start_cond, ui_cond, ui_chk_en;
   logic ui_sp_stack, ui_console, ui_ld_ba, ui_ld_d, ui_ld_b, ui_ld_ps;
   logic ui_ld_ir, ui_sp_wr, ui_sp_rd, ui_flag_clr, bus_a_oe, bus_d_oe;
   logic bus_c_oe, msyn_in, msyn_out, ssyn_in, ssyn_out, nonprocessor_request;
   logic br_in, npg_out, bg_out, sack_in, bbsy_in, bbsy_out, arb_tmo, pwr_ok;
   logic ac_low, dc_low, bus_init, busy, err_odd, err_stack, err_dto, mute;
   logic flag_start, flag_cont, flag_exam, flag_dep, con_incr;
   logic [1:0]  ui_xfer, ui_dsel, bus_c_in, bus_c_out;
   logic [3:0]  ui_sp_addr;
   logic [5:0]  con_sw, con_event;
   logic [7:0]  processor_status_reg;
   logic [15:0] alu_out, operand_a, b_reg, instruction_reg, sw_reg, disp_data;
   logic [15:0] disp_addr, bus_a_in, bus_a_out, bus_d_in, bus_d_out;
   int          fail_count = 0;
   int          samples_checked = 0;

   // Short counts keep the run quick
   pbid_core #(.DTO_CYC(8), .ARB_CYC(8), .PWR_CYC(8)) uut (.*);
   pbid_slave_model #(.LAT(3)) slave (.clk_sys, .mute, .bus_a_out,
      .bus_d_out, .bus_c_out, .msyn_out, .bus_d_in, .ssyn_in);

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // -----------------------------------------------------------------
   // Shared helpers
   // -----------------------------------------------------------------
   task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(int n = 1);
      repeat (n) @(negedge clk_sys);
   endtask
   // Bounded wait for a level
   task automatic wt(ref logic s, input logic lvl, input int n,
                     input string what);
      for (int i = 0; i < n && s !== lvl; i++) tick();
      chk(what, {15'h0, s}, {15'h0, lvl});
   endtask
   task automatic ld(ref logic en, input logic [15:0] v);
      alu_out = v;
      en = 1'b1;
      tick();
      en = 1'b0;
   endtask
   task automatic xfer(logic [1:0] t, logic [15:0] a, logic [15:0] d);
      ld(ui_ld_d, d);
      ld(ui_ld_ba, a);
      ui_xfer = t;
      ui_bus_start = 1'b1;
      tick();
      ui_bus_start = 1'b0;
   endtask
   task automatic print_verdict();
      if (fail_count == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_power();
      pwr_ok = 1'b1;
      wt(bus_init, 1'b0, 60, "init release");
      chk("lows at init release", {14'h0, ac_low, dc_low}, 16'h0);
      pwr_ok = 1'b0;
      wt(ac_low, 1'b1, 40, "ac low");
      chk("dc low before ac low", {15'h0, dc_low}, 16'h0);
      wt(dc_low, 1'b1, 40, "dc low");
      pwr_ok = 1'b1;
      wt(bus_init, 1'b0, 60, "init again");
   endtask
   task automatic t_path();
      ui_sp_wr = 1'b1;
      ui_sp_addr = 4'h3;
      alu_out = 16'h1234;
      tick();
      ui_sp_addr = 4'h5;
      alu_out = 16'hABCD;
      tick();
      ui_sp_wr = 1'b0;
      ui_sp_rd = 1'b1;
      ui_sp_addr = 4'h3;
      tick();
      chk("operand a", operand_a, 16'h1234);
      ui_sp_rd = 1'b0;
      ui_dsel = `PBID_DS_RD;
      ld(ui_ld_b, 16'h0000);
      chk("staged b", b_reg, 16'h1234);
      ui_sp_rd = 1'b1;
      ui_sp_addr = 4'h5;
      tick();
      ui_sp_rd = 1'b0;
      chk("second operand", operand_a, 16'hABCD);
      chk("b held", b_reg, 16'h1234);
      tick(2);
      chk("data display", disp_data, 16'hABCD);
      ld(ui_ld_ir, 16'h0F0F);
      chk("instruction reg", instruction_reg, 16'hABCD);
   endtask
   // Writes, then reads back; odd DATOB is legal
   task automatic t_xfer();
      logic [1:0]  ty [4] = '{`PBID_XF_DATO, `PBID_XF_DATOB,
                              `PBID_XF_DATI, `PBID_XF_DATIP};
      logic [15:0] ad [4] = '{16'h0010, 16'h0013, 16'h0010, 16'h0012};
      logic [15:0] dt [4] = '{16'h5A5A, 16'h00C3, 16'h5A5A, 16'h00C3};
      for (int i = 0; i < 4; i++) begin
         xfer(ty[i], ad[i], dt[i]);
         wt(ssyn_in, 1'b1, 20, "slave answer");
         chk("address out", bus_a_out, ad[i]);
         chk("type out", {14'h0, bus_c_out}, {14'h0, ty[i]});
         chk("address display", disp_addr, ad[i]);
         if (!ty[i][1]) begin
            tick(3);
            chk("sync held", {15'h0, msyn_out}, 16'h1);
            ui_dsel = `PBID_DS_BUS;
            ld(ui_ld_d, 16'h0000);
            ld(ui_ld_b, 16'h0000);
            chk("read data", b_reg, dt[i]);
         end else
            chk("write data", bus_d_out, dt[i]);
         wt(busy, 1'b0, 20, "transfer end");
         tick();
      end
      chk("odd byte write", {15'h0, err_odd}, 16'h0);
      ui_start_cond = 1'b1;
      xfer(`PBID_XF_DATO, 16'h0020, 16'h1111);
      tick(5);
      chk("gated start", {15'h0, msyn_out}, 16'h0);
      ui_start_cond = 1'b0;
   endtask
   task automatic t_err();
      mute = 1'b1;
      xfer(`PBID_XF_DATI, 16'h0004, 16'h0000);
      wt(err_dto, 1'b1, 30, "data time-out");
      wt(busy, 1'b0, 10, "abandoned transfer");
      mute = 1'b0;
      xfer(`PBID_XF_DATO, 16'h0005, 16'h0000);
      wt(err_odd, 1'b1, 6, "odd address");
      chk("no sync on error", {15'h0, msyn_out}, 16'h0);
      ui_sp_stack = 1'b1;
      xfer(`PBID_XF_DATO, 16'h0040, 16'h0000);
      chk("stack limit", {15'h0, err_stack}, 16'h1);
   endtask
   task automatic t_slave();
      ui_console = 1'b1;
      sw_reg = 16'hC35A;
      bus_a_in = `PBID_SR_ADDR;
      msyn_in = 1'b1;
      wt(ssyn_out, 1'b1, 8, "slave sync");
      chk("switch value", bus_d_out, 16'hC35A);
      chk("data drive", {15'h0, bus_d_oe}, 16'h1);
      msyn_in = 1'b0;
      wt(ssyn_out, 1'b0, 8, "slave release");
      xfer(`PBID_XF_DATI, `PBID_SR_ADDR, 16'h0000);
      chk("switches", bus_d_out, 16'hC35A);
      tick(9);
      ld(ui_ld_d, 16'h0000);
   endtask
   // Each switch, then a chained examine
   task automatic t_console();
      for (int i = 0; i < 8; i++) begin
         con_sw = (i < 6) ? 6'(1 << i) : 6'h08;
         for (int n = 0; n < 8 && con_event === 6'h00; n++) tick();
         chk("switch event", {10'h0, con_event}, {10'h0, con_sw});
         con_sw = 6'h00;
         tick(4);
      end
      chk("start and cont", {14'h0, flag_start, flag_cont}, 16'h3);
      chk("chained examine", {15'h0, con_incr}, 16'h1);
      ui_flag_clr = 1'b1;
      tick();
      ui_flag_clr = 1'b0;
      chk("flags cleared", {14'h0, flag_start, flag_cont}, 16'h0);
   endtask
   // Silent requester: the grant times out
   task automatic t_arb();
      nonprocessor_request = 1'b1;
      br_in = 1'b1;
      wt(npg_out, 1'b1, 10, "npr grant");
      chk("bus grant held off", {15'h0, bg_out}, 16'h0);
      wt(arb_tmo, 1'b1, 20, "grant time-out");
      nonprocessor_request = 1'b0;
      br_in = 1'b0;
   endtask

   initial begin
      {ui_bus_start, ui_start_cond, ui_cond, ui_xfer, ui_sp_stack, ui_console,
       ui_dsel, ui_ld_ba, ui_ld_d, ui_ld_b, ui_ld_ps, ui_ld_ir, ui_sp_wr,
       ui_sp_rd, ui_sp_addr, alu_out, ui_flag_clr, sw_reg, con_sw, bus_a_in,
       bus_c_in, msyn_in, nonprocessor_request, br_in, sack_in, bbsy_in,
       pwr_ok, mute} = '0;
      ui_chk_en = 1'b1;
      srst = 1'b1;
      tick(10);
      chk("reset levels", {ac_low, dc_low, bus_init, msyn_out}, 16'hE);
      srst = 1'b0;
      t_power();
      t_path();
      t_xfer();
      t_slave();
      t_console();
      t_arb();
      t_err();
      print_verdict();
   end
   // Run needs under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk_sys);
      fail_count++;
      print_verdict();
   end
endmodule
